// ===== core/gscw_consts.vh
// Purpose: constants for the gateway status and control word bank
// Assumes: byte-wide process data port, word held msb first
// Notes:   definitions only
`ifndef GSCW_CONSTS_VH
`define GSCW_CONSTS_VH
// ****************************************
// addresses and widths
// ****************************************
`define GSCW_AW            10
`define GSCW_STAT_HI_ADDR  10'h000
`define GSCW_STAT_LO_ADDR  10'h001
`define GSCW_CTRL_HI_ADDR  10'h200
`define GSCW_CTRL_LO_ADDR  10'h201
// ****************************************
// configuration selection
// ****************************************
`define GSCW_CFG_OFF       2'h0
`define GSCW_CFG_LOCK      2'h1
`define GSCW_CFG_NOLOCK    2'h2
// ****************************************
// status word fields
// ****************************************
`define GSCW_SR_SEND       15
`define GSCW_SR_CONF       14
`define GSCW_SR_VALID      13
`define GSCW_SR_CODE_HI    12
`define GSCW_SR_CODE_LO    8
// ****************************************
// control word fields
// ****************************************
`define GSCW_CR_CONF       15
`define GSCW_CR_SEND       14
`define GSCW_CR_VALID      13
`define GSCW_CR_EXEC       12
`define GSCW_CR_CMD_HI     11
`define GSCW_CR_CMD_LO     8
// ****************************************
// status report codes and commands
// ****************************************
`define GSCW_RPT_RETX      5'h00
`define GSCW_RPT_MISS1     5'h01
`define GSCW_RPT_MISSN     5'h02
`define GSCW_RPT_OVRN      5'h03
`define GSCW_RPT_OTHER     5'h04
`define GSCW_RPT_NOERR     5'h1F
`define GSCW_CMD_DIS       4'h0
`define GSCW_CMD_EN        4'h1
`define GSCW_CMD_FIRSTN    4'h2
`define GSCW_WORD_RST      16'h0000
`endif

// ===== core/gscw_regs.v
// Purpose: status word and control word bank of a fieldbus gateway
// Assumes: all inputs come from logic on core_clk; single byte port
// Notes:   bytes outside the two words are left to the process data store
//
// Function
// - words stay inactive after power-up; active only when configured
// - status word at input bytes 0x000-0x001, control at 0x200-0x201
// - each word held msb first at the lower address
// - fully enabled: no subnetwork exchange until control valid bit set
// - disabled or no start-up lock: exchange starts once fieldbus online
// - status valid bit is never cleared by the device once set
// - status bit 13 set once all transactions succeeded, master mode only
// - status bit 15 is send flag, bit 14 is confirm flag
// - status bits 12..8 hold report code, bits 7..0 report data
// - code 0x00 warning on retransmission count rise, data is counter
// - code 0x01 one node missing with address, 0x02 several with count
// - code 0x03 excess data warning, 0x04 undefined error, both address
// - once an error is resolved, report code 0x1F with no data
// - warnings may stand without a following no-error report
// - both parties follow a send/confirm handshake on the words
// - with start-up lock, subnetwork exchange only while control bit 13 is one
// - commands: 0x00 disable node, 0x01 enable node, 0x02 enable first N
`timescale 1ns/1ps
`include "gscw_consts.vh"

module gscw_regs #(
  parameter NODE_CNT = 32
) (
  // clock and reset
  input  wire                   core_clk,
  input  wire                   rst,
  // configuration and fieldbus state
  input  wire [1:0]             cfg_mode,
  input  wire                   master_mode,
  input  wire                   fb_online,
  // process data byte port from the fieldbus side
  input  wire [`GSCW_AW-1:0]    fb_addr,
  input  wire                   fb_wr,
  input  wire                   fb_rd,
  input  wire [7:0]             fb_wdata,
  output reg  [7:0]             fb_rdata,
  output wire                   fb_word_sel,
  // subnetwork events
  input  wire                   ev_all_done,
  input  wire                   ev_retx,
  input  wire                   ev_miss_one,
  input  wire                   ev_miss_many,
  input  wire                   ev_overrun,
  input  wire                   ev_other,
  input  wire                   ev_resolved,
  input  wire [7:0]             ev_data,
  // subnetwork control
  output wire                   exchange_en,
  output reg  [NODE_CNT-1:0]    node_enable,
  output reg                    cmd_pulse,
  output reg  [3:0]             cmd_code,
  output reg  [7:0]             cmd_data
);

  // ****************************************
  // start-up states
  // ****************************************
  localparam [2:0] ST_OFF  = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_RUN  = 3'b100;

  reg [2:0]  state_q;
  reg [2:0]  state_d;
  reg        active_q;
  reg [15:0] ctrl_q;
  reg        sr_send_q;
  reg        sr_conf_q;
  reg        sr_valid_q;
  reg [4:0]  rpt_code_q;
  reg [7:0]  rpt_data_q;
  reg        pend_q;
  reg [4:0]  pend_code_q;
  reg [7:0]  pend_data_q;
  reg        err_q;
  reg        cr_send_seen_q;

  wire [15:0] status_word;
  wire        ctrl_hi_wr;
  wire        ctrl_lo_wr;
  wire        publish;
  wire        new_cmd;
  wire        ev_any;
  wire        ev_err;
  reg  [4:0]  ev_code;

  // word byte decode for fb_word_sel and the read path; control writes compare their addresses directly
  function is_word_addr;
    input [`GSCW_AW-1:0] a;
    begin
      is_word_addr = (a == `GSCW_STAT_HI_ADDR) || (a == `GSCW_STAT_LO_ADDR) ||
                     (a == `GSCW_CTRL_HI_ADDR) || (a == `GSCW_CTRL_LO_ADDR);
    end
  endfunction

  // ****************************************
  // activation and byte access
  // ****************************************

  // configuration is sampled on every clock, words follow it one clock late and stay off until then
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      active_q <= 1'b0;
    end else begin
      active_q <= (cfg_mode != `GSCW_CFG_OFF);
    end
  end

  // the block claims its four bytes only while the words are active
  assign fb_word_sel = active_q && is_word_addr(fb_addr);
  assign ctrl_hi_wr  = fb_wr && active_q && (fb_addr == `GSCW_CTRL_HI_ADDR);
  assign ctrl_lo_wr  = fb_wr && active_q && (fb_addr == `GSCW_CTRL_LO_ADDR);

  assign status_word = {sr_send_q, sr_conf_q, sr_valid_q, rpt_code_q, rpt_data_q};

  // control word bytes, high byte at the lower address
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `GSCW_WORD_RST;
    end else begin
      if (ctrl_hi_wr) begin
        ctrl_q[15:8] <= fb_wdata;
      end
      if (ctrl_lo_wr) begin
        ctrl_q[7:0] <= fb_wdata;
      end
    end
  end

  // registered read, data one clock after the strobe
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fb_rdata <= 8'h00;
    end else if (fb_rd) begin
      if (!fb_word_sel) begin
        fb_rdata <= 8'h00;
      end else begin
        case (fb_addr)
          `GSCW_STAT_HI_ADDR: begin
            fb_rdata <= status_word[15:8];
          end
          `GSCW_STAT_LO_ADDR: begin
            fb_rdata <= status_word[7:0];
          end
          `GSCW_CTRL_HI_ADDR: begin
            fb_rdata <= ctrl_q[15:8];
          end
          default: begin
            fb_rdata <= ctrl_q[7:0];
          end
        endcase
      end
    end
  end

  // ****************************************
  // start-up gate for subnetwork exchange
  // ****************************************

  // without the lock the gate opens two clocks after the fieldbus goes online and closes at once when it drops
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (fb_online) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!fb_online) begin
          state_d = ST_OFF;
        end else if (cfg_mode != `GSCW_CFG_LOCK || !active_q) begin
          state_d = ST_RUN;
        end else if (ctrl_q[`GSCW_CR_VALID]) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!fb_online) begin
          state_d = ST_OFF;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // with the lock, dropping the valid bit halts exchange again at once
  assign exchange_en = (state_q == ST_RUN) && fb_online &&
                       (cfg_mode != `GSCW_CFG_LOCK || !active_q ||
                        ctrl_q[`GSCW_CR_VALID]);

  // ****************************************
  // status reports
  // ****************************************

  assign ev_any = ev_retx | ev_miss_one | ev_miss_many | ev_overrun | ev_other;
  assign ev_err = ev_miss_one | ev_miss_many | ev_other;

  // priority: errors before warnings when several arrive together
  always @* begin
    ev_code = `GSCW_RPT_RETX;
    if (ev_miss_one) begin
      ev_code = `GSCW_RPT_MISS1;
    end else if (ev_miss_many) begin
      ev_code = `GSCW_RPT_MISSN;
    end else if (ev_other) begin
      ev_code = `GSCW_RPT_OTHER;
    end else if (ev_overrun) begin
      ev_code = `GSCW_RPT_OVRN;
    end
  end

  // a new report goes out only once the control side confirmed the last one
  assign publish = pend_q && (ctrl_q[`GSCW_CR_CONF] == sr_send_q);

  // pending slot keeps the most recent report; a new event beats the publish
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_q      <= 1'b0;
      pend_code_q <= `GSCW_RPT_NOERR;
      pend_data_q <= 8'h00;
      err_q       <= 1'b0;
    end else begin
      if (ev_any) begin
        pend_q      <= 1'b1;
        pend_code_q <= ev_code;
        pend_data_q <= ev_data;
      end else if (ev_resolved && err_q) begin
        pend_q      <= 1'b1;
        pend_code_q <= `GSCW_RPT_NOERR;
        pend_data_q <= 8'h00;
      end else if (publish) begin
        pend_q <= 1'b0;
      end
      // warnings leave the error flag alone, they need no closing report
      if (ev_err) begin
        err_q <= 1'b1;
      end else if (ev_resolved) begin
        err_q <= 1'b0;
      end
    end
  end

  // published report, send flag toggles with every new one
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sr_send_q  <= 1'b0;
      rpt_code_q <= `GSCW_RPT_NOERR;
      rpt_data_q <= 8'h00;
    end else if (publish && active_q) begin
      sr_send_q  <= ~sr_send_q;
      rpt_code_q <= pend_code_q;
      rpt_data_q <= pend_data_q;
    end
  end

  // sticky valid flag; only reset clears it
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sr_valid_q <= 1'b0;
    end else if (ev_all_done && master_mode) begin
      sr_valid_q <= 1'b1;
    end
  end

  // ****************************************
  // commands from the control word
  // ****************************************

  // a toggled control send flag marks a new control word; confirm copies it
  assign new_cmd = active_q && (ctrl_q[`GSCW_CR_SEND] != cr_send_seen_q);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cr_send_seen_q <= 1'b0;
      sr_conf_q      <= 1'b0;
      cmd_pulse      <= 1'b0;
      cmd_code       <= 4'h0;
      cmd_data       <= 8'h00;
    end else begin
      cmd_pulse <= new_cmd && ctrl_q[`GSCW_CR_EXEC];
      if (new_cmd) begin
        cr_send_seen_q <= ctrl_q[`GSCW_CR_SEND];
        sr_conf_q      <= ctrl_q[`GSCW_CR_SEND];
      end
      // fields follow executed commands only; a confirm-only word leaves them
      if (new_cmd && ctrl_q[`GSCW_CR_EXEC]) begin
        cmd_code <= ctrl_q[`GSCW_CR_CMD_HI:`GSCW_CR_CMD_LO];
        cmd_data <= ctrl_q[7:0];
      end
    end
  end

  // node mask: one bit per configured node, out of range addresses ignored
  genvar gi;
  generate
    for (gi = 0; gi < NODE_CNT; gi = gi + 1) begin : g_node
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          node_enable[gi] <= 1'b1;
        end else if (cmd_pulse) begin
          case (cmd_code)
            `GSCW_CMD_DIS: begin
              if (cmd_data == gi) begin
                node_enable[gi] <= 1'b0;
              end
            end
            `GSCW_CMD_EN: begin
              if (cmd_data == gi) begin
                node_enable[gi] <= 1'b1;
              end
            end
            `GSCW_CMD_FIRSTN: begin
              node_enable[gi] <= (gi < cmd_data);
            end
            default: begin
              node_enable[gi] <= node_enable[gi];
            end
          endcase
        end
      end
    end
  endgenerate

endmodule

// ===== testbench/gscw_plc.sv
// Purpose: control system model on the process data byte port
// Assumes: strobes change just after rising edges, one edge per byte
// Notes:   keeps a shadow of the control word it last wrote
`timescale 1ns/1ps
`include "gscw_consts.vh"
module gscw_plc (
  // clock and fieldbus state
  input  wire                core_clk,
  input  wire                fb_online,
  // byte port
  output reg  [`GSCW_AW-1:0] fb_addr,
  output reg                 fb_wr,
  output reg                 fb_rd,
  output reg  [7:0]          fb_wdata,
  input  wire [7:0]          fb_rdata
);
  // ****************************************
  // bus cycles
  // ****************************************
  reg [15:0] ctl_q = 16'h0000;
  initial begin
    fb_addr = 10'h3FF;
    fb_wr = 1'b0;
    fb_rd = 1'b0;
    fb_wdata = 8'h00;
  end
  // released data line shows the inverse so stale bytes never pass
  task xfer(input w, input [`GSCW_AW-1:0] a, input [7:0] v, output [7:0] q);
    @(posedge core_clk);
    fb_addr <= a;
    fb_wr <= w;
    fb_rd <= !w;
    fb_wdata <= v;
    @(posedge core_clk);
    fb_wr <= 1'b0;
    fb_rd <= 1'b0;
    fb_wdata <= ~v;
    #1 q = fb_rdata;
  endtask
  // msb byte sits at the lower address
  task rd_stat(output [15:0] s);
    xfer(1'b0, `GSCW_STAT_HI_ADDR, 8'h00, s[15:8]);
    xfer(1'b0, `GSCW_STAT_LO_ADDR, 8'h00, s[7:0]);
  endtask
  // low byte first so the send toggle in the high byte lands last
  task wr_ctl(input [15:0] c);
    reg [7:0] q;
    ctl_q = c;
    xfer(1'b1, `GSCW_CTRL_LO_ADDR, c[7:0], q);
    xfer(1'b1, `GSCW_CTRL_HI_ADDR, c[15:8], q);
  endtask
  // offline entry and start-up; also used after the device drops off
  task start_up;
    reg [15:0] s;
    integer i;
    wr_ctl(ctl_q & 16'hDFFF);
    for (i = 0; i < 50 && !fb_online; i = i + 1)
      @(posedge core_clk);
    rd_stat(s);
    for (i = 0; i < 20 && s[13]; i = i + 1)
      rd_stat(s);
    wr_ctl(ctl_q | 16'h2000);
  endtask
  // confirm a report by copying its send flag
  task ack;
    reg [15:0] s;
    rd_stat(s);
    wr_ctl({s[15], ctl_q[14:0]});
  endtask
  // toggle send, then wait bounded for the device confirm
  task cmd(input e, input [3:0] k, input [7:0] v);
    reg [15:0] s;
    integer i;
    wr_ctl({ctl_q[15], ~ctl_q[14], ctl_q[13], e, k, v});
    rd_stat(s);
    for (i = 0; i < 20 && s[14] !== ctl_q[14]; i = i + 1)
      rd_stat(s);
  endtask
endmodule

// ===== testbench/gscw_regs_monitor.sv
// Purpose: port-level checker for the status and control word bank
// Assumes: one clock domain, rst asynchronous and active high
// Notes:   bound to every instance of the bank
`timescale 1ns/1ps
`include "gscw_consts.vh"
module gscw_regs_monitor #(
  parameter NODE_CNT = 32
) (
  input wire                core_clk,
  input wire                rst,
  input wire [1:0]          cfg_mode,
  input wire                fb_online,
  input wire [`GSCW_AW-1:0] fb_addr,
  input wire                fb_rd,
  input wire [7:0]          fb_rdata,
  input wire                fb_word_sel,
  input wire                exchange_en,
  input wire [NODE_CNT-1:0] node_enable,
  input wire                cmd_pulse,
  input wire [3:0]          cmd_code,
  input wire [7:0]          cmd_data
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_sel_map: assert property (fb_word_sel |-> fb_addr inside {`GSCW_STAT_HI_ADDR,
    `GSCW_STAT_LO_ADDR, `GSCW_CTRL_HI_ADDR, `GSCW_CTRL_LO_ADDR}) else $error("bad word select");
  a_off_sel: assert property ($past(cfg_mode) == `GSCW_CFG_OFF |-> !fb_word_sel)
    else $error("select while words off");
  a_rdata_hold: assert property (!$past(fb_rd) |-> $stable(fb_rdata))
    else $error("read data moved without read");
  a_nonword_zero: assert property (fb_rd && !fb_word_sel |=> fb_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_exch_online: assert property (exchange_en |-> fb_online)
    else $error("exchange while offline");
  a_nolock_run: assert property ((cfg_mode != `GSCW_CFG_LOCK && fb_online) [*4]
    |-> exchange_en) else $error("no exchange without lock");
  a_pulse_once: assert property (cmd_pulse |=> !cmd_pulse)
    else $error("command pulse too long");
  a_node_cause: assert property (!$stable(node_enable) |-> $past(cmd_pulse))
    else $error("node mask moved without command");
  a_cmd_cause: assert property (!$stable({cmd_code, cmd_data}) |-> cmd_pulse)
    else $error("command fields moved without pulse");
  // main scenarios reached
  cover property (cmd_pulse);
  cover property (exchange_en && cfg_mode == `GSCW_CFG_LOCK);
  cover property (fb_rd && fb_word_sel);
endmodule
bind gscw_regs gscw_regs_monitor #(.NODE_CNT(NODE_CNT)) gscw_regs_monitor_i (.core_clk, .rst,
  .cfg_mode, .fb_online, .fb_addr, .fb_rd, .fb_rdata, .fb_word_sel, .exchange_en,
  .node_enable, .cmd_pulse, .cmd_code, .cmd_data);

// ===== testbench/gscw_regs_tb_top.sv
// Purpose: self-checking bench for the status and control word bank
// Assumes: control system model drives the byte port
// Notes:   expected words come from an integer model in this file
`timescale 1ns/1ps
`include "gscw_consts.vh"
module gscw_regs_tb_top;
  localparam NC = 8;
  reg                 core_clk = 1'b0;
  reg                 rst = 1'b1;
  reg  [1:0]          cfg_mode = `GSCW_CFG_OFF;
  reg                 master_mode = 1'b0;
  reg                 fb_online = 1'b0;
  reg  [6:0]          ev_q = 7'h00;
  reg  [7:0]          ev_data = 8'h00;
  wire [`GSCW_AW-1:0] fb_addr;
  wire                fb_wr, fb_rd, fb_word_sel, exchange_en, cmd_pulse;
  wire [7:0]          fb_wdata, fb_rdata, cmd_data;
  wire [3:0]          cmd_code;
  wire [NC-1:0]       node_enable;
  integer             n_mismatch = 0, check_count = 0, seed = 43027, i, nodes, n;
  reg  [15:0]         s, sw;
  reg  [7:0]          d;
  // ****************************************
  // structure
  // ****************************************
  always #25 core_clk = ~core_clk;
  gscw_regs #(.NODE_CNT(NC)) gscw_regs_i (.core_clk(core_clk), .rst(rst), .cfg_mode(cfg_mode),
    .master_mode(master_mode), .fb_online(fb_online), .fb_addr(fb_addr), .fb_wr(fb_wr),
    .fb_rd(fb_rd), .fb_wdata(fb_wdata), .fb_rdata(fb_rdata), .fb_word_sel(fb_word_sel),
    .ev_all_done(ev_q[6]), .ev_retx(ev_q[0]), .ev_miss_one(ev_q[1]), .ev_miss_many(ev_q[2]),
    .ev_overrun(ev_q[3]), .ev_other(ev_q[4]), .ev_resolved(ev_q[5]), .ev_data(ev_data),
    .exchange_en(exchange_en), .node_enable(node_enable), .cmd_pulse(cmd_pulse),
    .cmd_code(cmd_code), .cmd_data(cmd_data));
  gscw_plc gscw_plc_i (.core_clk(core_clk), .fb_online(fb_online), .fb_addr(fb_addr),
    .fb_wr(fb_wr), .fb_rd(fb_rd), .fb_wdata(fb_wdata), .fb_rdata(fb_rdata));
  // ****************************************
  // helpers
  // ****************************************
  task chk(input [31:0] seen, input [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle event pulse, then time for the report to publish
  task pulse(input integer k, input [7:0] v);
    @(posedge core_clk);
    ev_q <= 7'h01 << k;
    ev_data <= v;
    @(posedge core_clk);
    ev_q <= 7'h00;
    repeat (3) @(posedge core_clk);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // a hang counts as a mismatch
  initial begin
    #(50 * 8000);
    n_mismatch = n_mismatch + 1;
    summarize;
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    gscw_plc_i.rd_stat(s);
    chk(s, 0);
    @(posedge core_clk);
    fb_online <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk(exchange_en, 1);
    // start-up lock: exchange waits for the control valid bit
    fb_online <= 1'b0;
    cfg_mode <= `GSCW_CFG_LOCK;
    repeat (3) @(posedge core_clk);
    sw = 16'h1F00;
    gscw_plc_i.rd_stat(s);
    chk(s, sw);
    @(posedge core_clk);
    fb_online <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk(exchange_en, 0);
    gscw_plc_i.start_up;
    repeat (2) @(posedge core_clk);
    chk(exchange_en, 1);
    // every report code, ending with the no-error report
    for (i = 0; i < 6; i = i + 1) begin
      d = $random(seed);
      pulse(i, d);
      sw = {~sw[15], sw[14:13], (i == 5) ? 5'h1F : i[4:0], (i == 5) ? 8'h00 : d};
      gscw_plc_i.rd_stat(s);
      chk(s, sw);
      gscw_plc_i.ack;
    end
    // status valid only in master operation
    pulse(6, 8'h00);
    gscw_plc_i.rd_stat(s);
    chk(s, sw);
    master_mode <= 1'b1;
    pulse(6, 8'h00);
    sw[13] = 1'b1;
    gscw_plc_i.rd_stat(s);
    chk(s, sw);
    // commands: first N, disable, enable, and a confirm-only toggle
    nodes = 8'hFF;
    n = {$random(seed)} % 9;
    for (i = 0; i < 4; i = i + 1) begin
      d = (i == 0) ? n : i;
      gscw_plc_i.cmd(i != 3, (i == 0) ? 4'h2 : (i == 2) ? 4'h1 : 4'h0, d);
      repeat (2) @(posedge core_clk);
      if (i == 0)
        nodes = (1 << n) - 1;
      else if (i == 1)
        nodes = nodes & ~(1 << d);
      else if (i == 2)
        nodes = nodes | (1 << d);
      chk(node_enable, nodes[NC-1:0]);
      sw[14] = gscw_plc_i.ctl_q[14];
      gscw_plc_i.rd_stat(s);
      chk(s, sw);
    end
    // device leaves the fieldbus: exchange stops, valid stays
    @(posedge core_clk);
    fb_online <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(exchange_en, 0);
    gscw_plc_i.rd_stat(s);
    chk(s, sw);
    summarize;
  end
endmodule
